//--- rtl/ch7r_params.svh
// Offsets, field positions, reset values and fixed codes of the channel 7
// divider, status and identification registers.
// Assumes word-wide (16-bit) register access from the serial port front end.
`ifndef CH7R_PARAMS_SVH
`define CH7R_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CH7R_OFS_INT_DIV_FRAC_HIGH 6'h13
`define CH7R_OFS_FRAC_DIV_LOW 6'h14
`define CH7R_OFS_PLL_STATUS 6'h15
`define CH7R_OFS_DEVICE_IDENT 6'h28

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CH7R_INT_DIV_MSB 11
`define CH7R_INT_DIV_LSB 4
`define CH7R_FRAC_HIGH_MSB 3
`define CH7R_FRAC_HIGH_LSB 0
`define CH7R_STAT_UNLOCK_BIT 2
`define CH7R_STAT_LOS_BIT 1
`define CH7R_STAT_SEL_BIT 0
`define CH7R_ID_VERSION_MSB 5
`define CH7R_ID_VERSION_LSB 3
`define CH7R_ID_DIE_MSB 2
`define CH7R_ID_DIE_LSB 0

// ---------------------------------------------------------------
// Reset values and fixed codes
// ---------------------------------------------------------------
`define CH7R_RST_INT_DIV_FRAC_HIGH 12'h008
`define CH7R_RST_FRAC_DIV_LOW 16'h0000
// Version and die codes are arbitrary neutral values
`define CH7R_VERSION_CODE 3'h5
`define CH7R_DIE_REV_PROTO 3'h4
`define CH7R_DIE_REV_PROD 3'h6

`endif

//--- rtl/ch7r_pkg.sv
// Types shared by the channel 7 register bank.
// Assumes the serial front end presents 6-bit word addresses, 16-bit data.
package ch7r_pkg;
   typedef logic [5:0] ch7r_addr_t;
   typedef logic [15:0] ch7r_word_t;
   typedef logic [7:0] ch7r_int_div_t;
   typedef logic [8:0] ch7r_ratio_t;
   typedef logic [19:0] ch7r_frac_t;
   typedef enum logic [1:0] {
      CH7R_ACC_IDLE,
      CH7R_ACC_READ,
      CH7R_ACC_WRITE
   } ch7r_acc_e;
endpackage

//--- rtl/ch7r_sync.sv
// Two-flop synchroniser, WIDTH bits wide, with asynchronous reset.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ns
module ch7r_sync #(
   parameter int WIDTH = 1,
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {WIDTH{RST_VAL}};
         sync_q <= {WIDTH{RST_VAL}};
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule // ch7r_sync

//--- rtl/ch7r_regs.sv
// Channel 7 divider settings, PLL status word and identification word.
// Assumes a serial (SPI or I2C) front end on mclk delivering whole-word
// read and write strobes; PLL status levels arrive asynchronously.
`timescale 1ns/1ns
`include "ch7r_params.svh"
module ch7r_regs #(
   parameter bit PRODUCTION = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire ch7r_pkg::ch7r_addr_t reg_addr,
   input wire ch7r_pkg::ch7r_word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output ch7r_pkg::ch7r_word_t reg_rdata,
   output logic reg_rvalid,
   output logic reg_miss,
   input wire logic ch7_fractional_path_enable,
   input wire logic lock_pin_route,
   input wire logic pll_locked,
   input wire logic ref_lost,
   input wire logic ref_secondary,
   output ch7r_pkg::ch7r_int_div_t ch7_integer_divider,
   output ch7r_pkg::ch7r_ratio_t ch7_divide_ratio,
   output ch7r_pkg::ch7r_frac_t ch7_fractional_divider,
   output logic ch7_fractional_active,
   output logic lock_status_pin
);
   import ch7r_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_n;

   // Release is synchronised, assertion stays immediate
   ch7r_sync #(
      .WIDTH(1),
      .RST_VAL(1'b0)
   ) u_rst_sync (
      .clk(mclk),
      .rst_n(reset_n),
      .din(1'b1),
      .dout(rst_n)
   );

   // ---------------------------------------------------------------
   // Status input synchronisers
   // ---------------------------------------------------------------
   logic [2:0] stat_raw;
   logic [2:0] stat_sync;
   logic locked_s;
   logic los_s;
   logic sec_s;

   // Analog side levels are not related to mclk
   assign stat_raw = {pll_locked, ref_lost, ref_secondary};

   // Reset to unlocked so a fresh part never claims lock
   ch7r_sync #(
      .WIDTH(3),
      .RST_VAL(1'b0)
   ) u_stat_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .din(stat_raw),
      .dout(stat_sync)
   );

   // Bit order follows the concatenation above
   assign locked_s = stat_sync[2];
   assign los_s = stat_sync[1];
   assign sec_s = stat_sync[0];

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   ch7r_acc_e acc;
   logic hit_div_high;
   logic hit_frac_low;
   logic hit_status;
   logic hit_ident;
   logic hit_any;

   // A simultaneous read and write is taken as a read
   always_comb begin
      if (reg_rd) begin
         acc = CH7R_ACC_READ;
      end else if (reg_wr) begin
         acc = CH7R_ACC_WRITE;
      end else begin
         acc = CH7R_ACC_IDLE;
      end
   end

   // Exact word match on the address;
   // anything else raises a miss pulse
   assign hit_div_high = (reg_addr == `CH7R_OFS_INT_DIV_FRAC_HIGH);
   assign hit_frac_low = (reg_addr == `CH7R_OFS_FRAC_DIV_LOW);
   assign hit_status = (reg_addr == `CH7R_OFS_PLL_STATUS);
   assign hit_ident = (reg_addr == `CH7R_OFS_DEVICE_IDENT);
   assign hit_any = hit_div_high | hit_frac_low | hit_status | hit_ident;

   // ---------------------------------------------------------------
   // Writable divider words
   // ---------------------------------------------------------------
   // Only bits 11:0 are kept; the upper nibble is expected to be zero
   logic [11:0] div_high_q;
   logic [11:0] div_high_d;
   ch7r_word_t frac_low_q;
   ch7r_word_t frac_low_d;

   // Status and ident words have no storage, so writes there vanish
   always_comb begin
      div_high_d = div_high_q;
      frac_low_d = frac_low_q;
      if (acc == CH7R_ACC_WRITE) begin
         if (hit_div_high) begin
            div_high_d = reg_wdata[11:0];
         end
         if (hit_frac_low) begin
            frac_low_d = reg_wdata;
         end
      end
   end

   // Writable words; reset restores the default divider setting
   // so the channel starts from a known ratio before any write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_high_q <= `CH7R_RST_INT_DIV_FRAC_HIGH;
         frac_low_q <= `CH7R_RST_FRAC_DIV_LOW;
      end else begin
         div_high_q <= div_high_d;
         frac_low_q <= frac_low_d;
      end
   end

   // ---------------------------------------------------------------
   // Live status and ident words
   // ---------------------------------------------------------------
   ch7r_word_t status_word;
   ch7r_word_t ident_word;
   logic [2:0] die_code;

   // Built fresh each cycle from the synchronised levels, never latched
   always_comb begin
      status_word = 16'h0000;
      status_word[`CH7R_STAT_UNLOCK_BIT] = ~locked_s;
      status_word[`CH7R_STAT_LOS_BIT] = los_s;
      status_word[`CH7R_STAT_SEL_BIT] = sec_s;
   end

   // Die flavour fixed when the block is built
   assign die_code = PRODUCTION ? `CH7R_DIE_REV_PROD : `CH7R_DIE_REV_PROTO;

   // Upper bits carry nothing and read zero for definiteness
   always_comb begin
      ident_word = 16'h0000;
      ident_word[`CH7R_ID_VERSION_MSB:`CH7R_ID_VERSION_LSB] = `CH7R_VERSION_CODE;
      ident_word[`CH7R_ID_DIE_MSB:`CH7R_ID_DIE_LSB] = die_code;
   end

   // ---------------------------------------------------------------
   // Read answer
   // ---------------------------------------------------------------
   ch7r_word_t rdata_q;
   ch7r_word_t rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   logic miss_q;
   logic miss_d;

   // Answer one cycle after the strobe; unmapped reads give zero
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      miss_d = 1'b0;
      if (acc != CH7R_ACC_IDLE) begin
         miss_d = ~hit_any;
      end
      if (acc == CH7R_ACC_READ) begin
         rvalid_d = 1'b1;
         rdata_d = 16'h0000;
         if (hit_div_high) begin
            rdata_d = {4'h0, div_high_q};
         end else if (hit_frac_low) begin
            rdata_d = frac_low_q;
         end else if (hit_status) begin
            rdata_d = status_word;
         end else if (hit_ident) begin
            rdata_d = ident_word;
         end
      end
   end

   // Answer flops; valid and miss drop after one cycle
   // because their next values default low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
         miss_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         miss_q <= miss_d;
      end
   end

   // Ports come straight from the answer flops
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign reg_miss = miss_q;

   // ---------------------------------------------------------------
   // Divider outputs
   // ---------------------------------------------------------------
   ch7r_int_div_t int_div_q;
   ch7r_int_div_t int_div_d;
   ch7r_ratio_t ratio_q;
   ch7r_ratio_t ratio_d;
   ch7r_frac_t frac_q;
   ch7r_frac_t frac_d;
   logic frac_act_q;
   logic frac_act_d;

   // Registered so the divider never sees a half-updated word mid-cycle;
   // the two fractional halves still land on separate writes
   always_comb begin
      int_div_d = div_high_q[`CH7R_INT_DIV_MSB:`CH7R_INT_DIV_LSB];
      ratio_d = {1'b0, int_div_d} + 9'h001;
      frac_act_d = ch7_fractional_path_enable;
      frac_d = 20'h00000;
      if (ch7_fractional_path_enable) begin
         frac_d = {div_high_q[`CH7R_FRAC_HIGH_MSB:`CH7R_FRAC_HIGH_LSB], frac_low_q};
      end
   end

   // Ratio resets to one to match the all-zero field;
   // fraction stays off until the enable is seen
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_div_q <= 8'h00;
         ratio_q <= 9'h001;
         frac_q <= 20'h00000;
         frac_act_q <= 1'b0;
      end else begin
         int_div_q <= int_div_d;
         ratio_q <= ratio_d;
         frac_q <= frac_d;
         frac_act_q <= frac_act_d;
      end
   end

   // Divider ports driven from their flops
   assign ch7_integer_divider = int_div_q;
   assign ch7_divide_ratio = ratio_q;
   assign ch7_fractional_divider = frac_q;
   assign ch7_fractional_active = frac_act_q;

   // ---------------------------------------------------------------
   // Lock status pin
   // ---------------------------------------------------------------
   logic lock_pin_q;
   logic lock_pin_d;

   // Pin sense is opposite to the register bit; low when not routed
   always_comb begin
      lock_pin_d = lock_pin_route & locked_s;
   end

   // Extra flop keeps the pin free of glitches while route toggles;
   // costs one cycle of latency on the lock indication
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_pin_q <= 1'b0;
      end else begin
         lock_pin_q <= lock_pin_d;
      end
   end

   // Pin driven from its flop
   assign lock_status_pin = lock_pin_q;
endmodule // ch7r_regs

//--- testbench/ch7r_regs_props.sv
// Port checker for the channel 7 register bank.
// Assumes it is bound to ch7r_regs built with the production die code.
`timescale 1ns/1ns
`include "ch7r_params.svh"
module ch7r_regs_props (
   input wire logic mclk,
   input wire logic reset_n,
   input wire ch7r_pkg::ch7r_addr_t reg_addr,
   input wire ch7r_pkg::ch7r_word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire ch7r_pkg::ch7r_word_t reg_rdata,
   input wire logic ch7_fractional_path_enable,
   input wire logic lock_pin_route,
   input wire logic pll_locked,
   input wire logic ref_lost,
   input wire logic ref_secondary,
   input wire ch7r_pkg::ch7r_int_div_t ch7_integer_divider,
   input wire ch7r_pkg::ch7r_ratio_t ch7_divide_ratio,
   input wire ch7r_pkg::ch7r_frac_t ch7_fractional_divider,
   input wire logic lock_status_pin
);
   import ch7r_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Status levels held long enough to cross the synchroniser
   sequence quiet_s;
      $stable({pll_locked, ref_lost, ref_secondary}) [*5];
   endsequence
   sequence rd_stat_s;
      reg_rd && reg_addr == `CH7R_OFS_PLL_STATUS;
   endsequence
   sequence wr_s(ch7r_addr_t a);
      reg_wr && !reg_rd && reg_addr == a;
   endsequence
   a_ratio_plus_one: assert property (ch7_divide_ratio == {1'b0, ch7_integer_divider} + 9'h001)
      else $error("ratio is not field plus one");
   a_int_from_write: assert property (wr_s(`CH7R_OFS_INT_DIV_FRAC_HIGH) |-> ##2
      ch7_integer_divider == $past(reg_wdata[11:4], 2)) else $error("integer field not applied");
   a_frac_low_write: assert property ((wr_s(`CH7R_OFS_FRAC_DIV_LOW) ##1 ch7_fractional_path_enable)
      |=> ch7_fractional_divider[15:0] == $past(reg_wdata, 2)) else $error("low fraction lost");
   a_frac_path_off: assert property (!ch7_fractional_path_enable |=> ch7_fractional_divider == 20'h00000)
      else $error("fraction live while disabled");
   a_status_zero_bits: assert property (rd_stat_s |=> reg_rdata[15:3] == 13'h0000)
      else $error("status upper bits not zero");
   a_status_live_bits: assert property ((quiet_s ##0 rd_stat_s) |=>
      reg_rdata[2:0] == {~pll_locked, ref_lost, ref_secondary}) else $error("status bits stale");
   a_ident_fields: assert property ((reg_rd && reg_addr == `CH7R_OFS_DEVICE_IDENT) |=>
      reg_rdata[5:0] == {`CH7R_VERSION_CODE, `CH7R_DIE_REV_PROD}) else $error("ident code wrong");
   a_lock_pin_high: assert property ((pll_locked && lock_pin_route) [*6] |=> lock_status_pin)
      else $error("lock pin low while locked");
endmodule // ch7r_regs_props

//--- testbench/ch7r_host.sv
// Host model: one word transfer per call on the strobe port.
// Assumes the bench calls xfer only after reset has settled.
`timescale 1ns/1ns
`include "ch7r_params.svh"
module ch7r_host (
   input wire logic mclk,
   output ch7r_pkg::ch7r_addr_t reg_addr,
   output ch7r_pkg::ch7r_word_t reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   import ch7r_pkg::*;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h2A;
      reg_wdata = 16'hA5A5;
   end
   // Idle lines carry an inverted copy so no stale word looks valid
   task automatic xfer(input ch7r_addr_t a, input ch7r_word_t d, input logic wr);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= (a == `CH7R_OFS_INT_DIV_FRAC_HIGH) ? (d & 16'h0FFF) : d;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule // ch7r_host

//--- testbench/tb.sv
// Self-checking bench for the channel 7 register bank.
// Assumes the host model and the port checker from this folder.
`timescale 1ns/1ns
`include "ch7r_params.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
   import ch7r_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic frac_en = 1'b0, route = 1'b0, locked = 1'b0, lost = 1'b0, sec = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, miss, frac_act, lock_pin;
   ch7r_addr_t reg_addr;
   ch7r_word_t reg_wdata, reg_rdata;
   ch7r_int_div_t idiv;
   ch7r_ratio_t ratio;
   ch7r_frac_t frac;
   ch7r_word_t exp_q[$], msk_q[$];
   logic mis_q[$];
   int error_cnt = 0, checks = 0;
   initial forever #10 mclk = ~mclk;
   ch7r_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));
   ch7r_regs u_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_miss(miss), .ch7_fractional_path_enable(frac_en), .lock_pin_route(route),
      .pll_locked(locked), .ref_lost(lost), .ref_secondary(sec), .ch7_integer_divider(idiv),
      .ch7_divide_ratio(ratio), .ch7_fractional_divider(frac), .ch7_fractional_active(frac_act),
      .lock_status_pin(lock_pin));
   // Each read answer against the oldest note, taken mid-cycle where it stands settled
   always @(negedge mclk) begin
      ch7r_word_t e, m;
      logic mx;
      if (reg_rvalid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
         m = (msk_q.size() > 0) ? msk_q.pop_front() : 16'hFFFF;
         mx = (mis_q.size() > 0) ? mis_q.pop_front() : 1'bx;
         `CHK("rdata", e, reg_rdata & m)
         `CHK("miss", mx, miss)
      end
   end
   task automatic rd(input ch7r_addr_t a, input ch7r_word_t e, input ch7r_word_t m = 16'hFFFF);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      mis_q.push_back(!(a inside {`CH7R_OFS_INT_DIV_FRAC_HIGH, `CH7R_OFS_FRAC_DIV_LOW,
         `CH7R_OFS_PLL_STATUS, `CH7R_OFS_DEVICE_IDENT}));
      u_host.xfer(a, 16'h0000, 1'b0);
   endtask
   // Divider outputs settle one edge after the write is taken
   task automatic outs(input ch7r_word_t hi, input ch7r_word_t lo, input logic en);
      repeat (3) @(posedge mclk);
      #1;
      `CHK("int", hi[11:4], idiv)
      `CHK("ratio", {1'b0, hi[11:4]} + 9'h001, ratio)
      `CHK("frac", en ? {hi[3:0], lo} : 20'h00000, frac)
      `CHK("frac_act", en, frac_act)
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Whole run is well under a thousand cycles; this cuts a hang short
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      ch7r_word_t hi, lo;
      logic [2:0] c;
      void'($urandom(31218));
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(`CH7R_OFS_INT_DIV_FRAC_HIGH, 16'h0008);
      rd(`CH7R_OFS_FRAC_DIV_LOW, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         hi = (i == 1) ? 16'h0FFF : 16'($urandom) & 16'h0FFF;
         lo = 16'($urandom);
         @(posedge mclk);
         frac_en <= i[0];
         u_host.xfer(`CH7R_OFS_INT_DIV_FRAC_HIGH, hi, 1'b1);
         u_host.xfer(`CH7R_OFS_FRAC_DIV_LOW, lo, 1'b1);
         outs(hi, lo, i[0]);
         rd(`CH7R_OFS_INT_DIV_FRAC_HIGH, hi);
         rd(`CH7R_OFS_FRAC_DIV_LOW, lo);
      end
      u_host.xfer(`CH7R_OFS_PLL_STATUS, 16'hFFFF, 1'b1);
      #1;
      `CHK("miss_ro", 1'b0, miss)
      u_host.xfer(`CH7R_OFS_DEVICE_IDENT, 16'hFFFF, 1'b1);
      rd(`CH7R_OFS_DEVICE_IDENT, {10'h000, `CH7R_VERSION_CODE, `CH7R_DIE_REV_PROD}, 16'h003F);
      for (int k = 0; k < 16; k++) begin
         c = k[2:0];
         @(posedge mclk);
         {locked, lost, sec} <= c;
         route <= k[3];
         repeat (5) @(posedge mclk);
         rd(`CH7R_OFS_PLL_STATUS, {13'h0000, ~c[2], c[1:0]});
         `CHK("lock_pin", k[3] & c[2], lock_pin)
      end
      rd(6'h3F, 16'h0000);
      u_host.xfer(6'h3E, 16'h1234, 1'b1);
      #1;
      `CHK("miss_wr", 1'b1, miss)
      repeat (4) @(posedge mclk);
      `CHK("pending", 0, exp_q.size())
      report_and_stop();
   end
endmodule // tb
bind ch7r_regs ch7r_regs_props u_props (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ch7_fractional_path_enable(ch7_fractional_path_enable), .lock_pin_route(lock_pin_route),
   .pll_locked(pll_locked), .ref_lost(ref_lost), .ref_secondary(ref_secondary),
   .ch7_integer_divider(ch7_integer_divider), .ch7_divide_ratio(ch7_divide_ratio),
   .ch7_fractional_divider(ch7_fractional_divider), .lock_status_pin(lock_status_pin));
